// >>> flow_ctl_pkg.sv
// Notes on behaviour
// - Request is posted write, command 1011xx
// - Command bit 2 set: doubleword length
// - Isochronous and coherent bits come from inputs
// - Channel set 2 carries four-bit channel number
// - Extended format flag is zero; one reserved
// - Basic format flag is one
// - Four-bit doubleword count split over bit-times
// - Base address bytes in bit-times four-seven
// - Error and chain bits kept; reserved zero
// - Payload follows request immediately
// - Sixteen two-bit fields per doubleword, low first
// - Doubleword M field N: stream M*16+N
// - At most 256 streams per message
// - Endpoint holds configurable reverse sink base
// - Fields passed raw with their stream indices
package flow_ctl_pkg;

  // ----------------------------------------------------------------
  // Packet geometry
  // ----------------------------------------------------------------
  localparam int HEADER_BYTES      = 8;
  localparam int DWORD_BYTES       = 4;
  localparam int MAX_DWORDS        = 16;
  localparam int FIELDS_PER_DWORD  = 16;
  localparam int FIELD_WIDTH       = 2;
  localparam int STREAMS_PER_MSG   = MAX_DWORDS * FIELDS_PER_DWORD;
  localparam int FIELD_BLOCK_BITS  = STREAMS_PER_MSG * FIELD_WIDTH;

  // ----------------------------------------------------------------
  // Command and header field values
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_UPPER_FC    = 4'hb;
  localparam logic [1:0] CHANNEL_SET_TWO = 2'h2;
  localparam logic       EXT_FORMAT_FC   = 1'h0;
  localparam logic       BASIC_FORMAT_FC = 1'h1;

  // Bit positions inside the 64-bit header (bit-time k is bits 8k+7:8k)
  localparam int POS_CMD_COHERENT = 0;
  localparam int POS_CMD_ISOC     = 1;
  localparam int POS_CMD_UPPER    = 2;
  localparam int POS_SEQ_HI       = 6;
  localparam int POS_UNIT         = 8;
  localparam int POS_SEQ0_CHAN3   = 13;
  localparam int POS_SEQ1         = 14;
  localparam int POS_PASS_PW      = 15;
  localparam int POS_CHAN_LO      = 16;
  localparam int POS_CHAIN        = 19;
  localparam int POS_DATA_ERROR   = 20;
  localparam int POS_COUNT_LO     = 22;
  localparam int POS_COUNT_HI     = 24;
  localparam int POS_BASIC_FMT    = 28;
  localparam int POS_EXT_FMT      = 30;
  localparam int POS_ADDRESS      = 32;

  // Reset value of byte and dword counters
  localparam logic [5:0] COUNT_RESET = 6'h00;

endpackage

// >>> fc_link_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Byte lane between the generating and the sinking endpoint
// ------------------------------------------------------------------
interface fc_link_if;
  logic       lane_valid;  // Byte present this cycle
  logic       lane_ctl;    // High for request bit-times, low for data
  logic [7:0] lane_data;   // One bit-time

  modport sender
  (
    output lane_valid,
    output lane_ctl,
    output lane_data
  );

  modport receiver
  (
    input lane_valid,
    input lane_ctl,
    input lane_data
  );
endinterface // fc_link_if

// >>> fc_request_generator.sv
`timescale 1ns/1ps
module fc_request_generator
  import flow_ctl_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  fc_link_if.sender                        link,
  input  wire logic                        send_start,
  input  wire logic                        isoc_mode,
  input  wire logic                        coherent_mode,
  input  wire logic [3:0]                  sequence_group_id,
  input  wire logic                        may_pass_posted_writes,
  input  wire logic [4:0]                  source_unit_number,
  input  wire logic [1:0]                  channel_set_select,
  input  wire logic [3:0]                  requested_channel_number,
  input  wire logic                        payload_error_bit,
  input  wire logic                        chain_bit,
  input  wire logic [31:0]                 message_base_address,
  input  wire logic [3:0]                  payload_dwords_minus_one,
  input  wire logic [FIELD_BLOCK_BITS-1:0] field_block,
  output logic                             busy,
  output logic                             send_done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {GEN_IDLE, GEN_HEAD, GEN_DATA} gen_phase_e;

  typedef struct packed {
    gen_phase_e                  phase;
    logic [5:0]                  cnt;
    logic [3:0]                  count;
    logic [63:0]                 hdr;
    logic [FIELD_BLOCK_BITS-1:0] fields;
    logic                        lane_valid;
    logic                        lane_ctl;
    logic [7:0]                  lane_data;
    logic                        done;
  } gen_state_s;

  gen_state_s state_reg;
  gen_state_s state_next;
  logic [63:0] hdr_build;

  // ----------------------------------------------------------------
  // Header assembly
  // ----------------------------------------------------------------
  always_comb
  begin
    hdr_build                                 = '0;                        // Reserved positions zero
    hdr_build[POS_CMD_UPPER +: 4]             = CMD_UPPER_FC;              // Posted write, dword length
    hdr_build[POS_CMD_ISOC]                   = isoc_mode;
    hdr_build[POS_CMD_COHERENT]               = coherent_mode;
    hdr_build[POS_SEQ_HI +: 2]                = sequence_group_id[3:2];
    hdr_build[POS_PASS_PW]                    = may_pass_posted_writes;
    hdr_build[POS_SEQ1]                       = sequence_group_id[1];
    hdr_build[POS_UNIT +: 5]                  = source_unit_number;
    if (channel_set_select == CHANNEL_SET_TWO)
    begin
      hdr_build[POS_SEQ0_CHAN3]               = requested_channel_number[3];
      hdr_build[POS_CHAN_LO +: 3]             = requested_channel_number[2:0];
    end
    else
    begin
      hdr_build[POS_SEQ0_CHAN3]               = sequence_group_id[0];
    end
    hdr_build[POS_DATA_ERROR]                 = payload_error_bit;
    hdr_build[POS_CHAIN]                      = chain_bit;
    hdr_build[POS_COUNT_LO +: 2]              = payload_dwords_minus_one[1:0];
    hdr_build[POS_COUNT_HI +: 2]              = payload_dwords_minus_one[3:2];
    hdr_build[POS_EXT_FMT]                    = EXT_FORMAT_FC;
    hdr_build[POS_BASIC_FMT]                  = BASIC_FORMAT_FC;
    hdr_build[POS_ADDRESS +: 32]              = message_base_address;      // Low byte first
  end

  // ----------------------------------------------------------------
  // Sequencer: header bytes, then payload bytes back to back
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next            = state_reg;
    state_next.lane_valid = 1'b0;
    state_next.lane_ctl   = 1'b0;
    state_next.lane_data  = 8'h00;
    state_next.done       = 1'b0;
    case (state_reg.phase)
      GEN_IDLE:
      begin
        if (send_start)
        begin
          state_next.phase  = GEN_HEAD;
          state_next.cnt    = COUNT_RESET;
          state_next.hdr    = hdr_build;
          state_next.fields = field_block;                     // Raw fields, no meaning imposed
          state_next.count  = payload_dwords_minus_one;        // Sixteen dwords cap at 256 streams
        end
      end
      GEN_HEAD:
      begin
        state_next.lane_valid = 1'b1;
        state_next.lane_ctl   = 1'b1;
        state_next.lane_data  = state_reg.hdr[{state_reg.cnt[2:0], 3'h0} +: 8];
        if (state_reg.cnt[2:0] == 3'h7)
        begin
          state_next.phase = GEN_DATA;                         // Payload directly after request
          state_next.cnt   = COUNT_RESET;
        end
        else
        begin
          state_next.cnt = state_reg.cnt + 6'h01;
        end
      end
      GEN_DATA:
      begin
        state_next.lane_valid = 1'b1;
        state_next.lane_data  = state_reg.fields[{state_reg.cnt, 3'h0} +: 8]; // Field 0 in low bits
        if (state_reg.cnt == {state_reg.count, 2'h3})
        begin
          state_next.phase = GEN_IDLE;
          state_next.done  = 1'b1;
        end
        else
        begin
          state_next.cnt = state_reg.cnt + 6'h01;
        end
      end
      default:
      begin
        state_next.phase = GEN_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign link.lane_valid = state_reg.lane_valid;
  assign link.lane_ctl   = state_reg.lane_ctl;
  assign link.lane_data  = state_reg.lane_data;
  assign busy            = (state_reg.phase != GEN_IDLE);
  assign send_done       = state_reg.done;

endmodule // fc_request_generator

// >>> fc_request_parser.sv
`timescale 1ns/1ps
module fc_request_parser
  import flow_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  fc_link_if.receiver      link,
  input  wire logic [31:0] reverse_sink_base_address,
  output logic             header_valid,
  output logic             isoc_mode,
  output logic             coherent_mode,
  output logic [3:0]       sequence_group_id,
  output logic             may_pass_posted_writes,
  output logic [4:0]       source_unit_number,
  output logic [3:0]       requested_channel_number,
  output logic             payload_error_bit,
  output logic             chain_bit,
  output logic [31:0]      message_base_address,
  output logic [3:0]       payload_dwords_minus_one,
  output logic             field_valid,
  output logic [31:0]      field_word,
  output logic [3:0]       dword_index,
  output logic [7:0]       first_stream_index,
  output logic [31:0]      first_stream_address,
  output logic             unsupported,
  output logic             protocol_error
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PAR_IDLE, PAR_HEAD, PAR_DATA, PAR_DROP} par_phase_e;

  typedef struct packed {
    par_phase_e  phase;
    logic [5:0]  cnt;
    logic [55:0] hdr;
    logic [23:0] acc;
    logic [3:0]  count;
    logic        header_valid;
    logic        isoc;
    logic        coherent;
    logic [3:0]  seq;
    logic        pass_pw;
    logic [4:0]  unit;
    logic [3:0]  chan;
    logic        data_error;
    logic        chain;
    logic [31:0] base;
    logic        field_valid;
    logic [31:0] word;
    logic [3:0]  dword;
    logic [7:0]  stream_index;
    logic [31:0] stream_address;
    logic        unsupported;
    logic        protocol_error;
  } par_state_s;

  par_state_s  state_reg;
  par_state_s  state_next;
  logic [63:0] hdr_full;
  logic        cmd_match;
  logic        format_bad;
  logic [3:0]  count_full;

  // ----------------------------------------------------------------
  // Header view with the byte arriving this cycle on top
  // ----------------------------------------------------------------
  always_comb
  begin
    hdr_full   = {link.lane_data, state_reg.hdr};
    cmd_match  = (link.lane_data[POS_CMD_UPPER +: 4] == CMD_UPPER_FC);
    format_bad = (hdr_full[POS_EXT_FMT] != EXT_FORMAT_FC) ||
                 (hdr_full[POS_BASIC_FMT] != BASIC_FORMAT_FC);
    count_full = {hdr_full[POS_COUNT_HI +: 2], hdr_full[POS_COUNT_LO +: 2]};
  end

  // ----------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next                = state_reg;
    state_next.header_valid   = 1'b0;
    state_next.field_valid    = 1'b0;
    state_next.unsupported    = 1'b0;
    state_next.protocol_error = 1'b0;
    case (state_reg.phase)
      PAR_IDLE:
      begin
        // Only a control byte with the flow control command opens a packet
        if (link.lane_valid && link.lane_ctl && cmd_match)
        begin
          state_next.phase          = PAR_HEAD;
          state_next.hdr            = {48'h0000_0000_0000, link.lane_data};
          state_next.cnt            = 6'h01;
        end
      end
      PAR_HEAD:
      begin
        if (link.lane_valid && !link.lane_ctl)
        begin
          state_next.phase          = PAR_IDLE;                 // Header cut short by data
          state_next.protocol_error = 1'b1;
        end
        else if (link.lane_valid && state_reg.cnt[2:0] != 3'h7)
        begin
          state_next.hdr[{state_reg.cnt[2:0], 3'h0} +: 8] = link.lane_data;
          state_next.cnt            = state_reg.cnt + 6'h01;
        end
        else if (link.lane_valid)
        begin
          state_next.cnt            = COUNT_RESET;
          state_next.count          = count_full;
          if (format_bad)
          begin
            state_next.phase        = PAR_DROP;                 // Skip payload, no decode
            state_next.unsupported  = 1'b1;
          end
          else
          begin
            state_next.phase        = PAR_DATA;                 // Payload expected next
            state_next.header_valid = 1'b1;
            state_next.isoc         = hdr_full[POS_CMD_ISOC];
            state_next.coherent     = hdr_full[POS_CMD_COHERENT];
            state_next.seq          = {hdr_full[POS_SEQ_HI +: 2], hdr_full[POS_SEQ1], hdr_full[POS_SEQ0_CHAN3]};
            state_next.pass_pw      = hdr_full[POS_PASS_PW];
            state_next.unit         = hdr_full[POS_UNIT +: 5];
            state_next.chan         = {hdr_full[POS_SEQ0_CHAN3], hdr_full[POS_CHAN_LO +: 3]};
            state_next.data_error   = hdr_full[POS_DATA_ERROR];
            state_next.chain        = hdr_full[POS_CHAIN];
            state_next.base         = hdr_full[POS_ADDRESS +: 32];
          end
        end
      end
      PAR_DATA, PAR_DROP:
      begin
        if (link.lane_valid && link.lane_ctl)
        begin
          state_next.phase          = PAR_IDLE;                 // Payload cut short by control
          state_next.protocol_error = 1'b1;
        end
        else if (link.lane_valid)
        begin
          if (state_reg.cnt[1:0] != 2'h3)
          begin
            state_next.acc[{state_reg.cnt[1:0], 3'h0} +: 8] = link.lane_data;
          end
          else if (state_reg.phase == PAR_DATA)
          begin
            state_next.field_valid    = 1'b1;
            state_next.word           = {link.lane_data, state_reg.acc};          // Raw fields
            state_next.dword          = state_reg.cnt[5:2];
            state_next.stream_index   = {state_reg.cnt[5:2], 4'h0};               // M*16
            state_next.stream_address = reverse_sink_base_address +
                                        {24'h00_0000, state_reg.cnt[5:2], 4'h0};
          end
          if (state_reg.cnt == {state_reg.count, 2'h3})
          begin
            state_next.phase        = PAR_IDLE;
            state_next.cnt          = COUNT_RESET;
          end
          else
          begin
            state_next.cnt          = state_reg.cnt + 6'h01;
          end
        end
      end
      default:
      begin
        state_next.phase = PAR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------
  assign header_valid             = state_reg.header_valid;
  assign isoc_mode                = state_reg.isoc;
  assign coherent_mode            = state_reg.coherent;
  assign sequence_group_id        = state_reg.seq;
  assign may_pass_posted_writes   = state_reg.pass_pw;
  assign source_unit_number       = state_reg.unit;
  assign requested_channel_number = state_reg.chan;
  assign payload_error_bit        = state_reg.data_error;
  assign chain_bit                = state_reg.chain;
  assign message_base_address     = state_reg.base;
  assign payload_dwords_minus_one = state_reg.count;
  assign field_valid              = state_reg.field_valid;
  assign field_word               = state_reg.word;
  assign dword_index              = state_reg.dword;
  assign first_stream_index       = state_reg.stream_index;
  assign first_stream_address     = state_reg.stream_address;
  assign unsupported              = state_reg.unsupported;
  assign protocol_error           = state_reg.protocol_error;

endmodule // fc_request_parser

// >>> fc_link_chk.sv
`timescale 1ns/1ps
module fc_link_chk
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       lane_valid,
  input wire logic       lane_ctl,
  input wire logic [7:0] lane_data
);
  // ------------------------------------------------------------------
  // Byte position tracking
  // ------------------------------------------------------------------
  logic       hdr_byte;
  logic       dat_byte;
  logic [3:0] hdr_idx_reg;
  logic [5:0] dat_idx_reg;
  logic [3:0] count_reg;

  // Header and payload bytes on the lane
  assign hdr_byte = lane_valid && lane_ctl;
  assign dat_byte = lane_valid && !lane_ctl;

  // Index of the current byte and the length count seen in the header
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      hdr_idx_reg <= 4'h0;
      dat_idx_reg <= 6'h00;
      count_reg   <= 4'h0;
    end
    else
    begin
      hdr_idx_reg <= hdr_byte ? hdr_idx_reg + 4'h1 : 4'h0;
      dat_idx_reg <= dat_byte ? dat_idx_reg + 6'h01 : 6'h00;
      if (hdr_byte && hdr_idx_reg == 4'h2)
        count_reg[1:0] <= lane_data[7:6];
      if (hdr_byte && hdr_idx_reg == 4'h3)
        count_reg[3:2] <= lane_data[1:0];
    end

  // ------------------------------------------------------------------
  // Lane properties
  // ------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  cmd_upper_a: assert property (hdr_byte && hdr_idx_reg == 4'h0 |-> lane_data[5:2] == 4'hb)
    else $error("command upper bits wrong");
  dword_len_a: assert property (hdr_byte && hdr_idx_reg == 4'h0 |-> lane_data[2])
    else $error("length unit bit not set");
  ext_fmt_a: assert property (hdr_byte && hdr_idx_reg == 4'h3 |-> !lane_data[6])
    else $error("extended format flag set");
  basic_fmt_a: assert property (hdr_byte && hdr_idx_reg == 4'h3 |-> lane_data[4])
    else $error("basic format flag clear");
  rsv_zero_a: assert property (hdr_byte && hdr_idx_reg == 4'h3 |-> {lane_data[7], lane_data[5], lane_data[3:2]} == 4'h0)
    else $error("reserved header bits set");
  rsv_bt2_a: assert property (hdr_byte && hdr_idx_reg == 4'h2 |-> !lane_data[5])
    else $error("reserved bit in third header byte set");
  header_run_a: assert property ($rose(hdr_byte) |-> hdr_byte[*8] ##1 dat_byte)
    else $error("header not eight bytes then payload");
  payload_run_a: assert property (dat_byte && dat_idx_reg != {count_reg, 2'b11} |=> dat_byte)
    else $error("payload ended early");
  payload_end_a: assert property (dat_byte && dat_idx_reg == {count_reg, 2'b11} |=> !lane_valid)
    else $error("payload longer than count");
endmodule // fc_link_chk

// >>> stream_flow_control_packet_codec_tb.sv
`timescale 1ns/1ps
module stream_flow_control_packet_codec_tb
  import flow_ctl_pkg::*;
;
  // ------------------------------------------------------------------
  // Stimulus, outputs and bookkeeping
  // ------------------------------------------------------------------
  logic                        clk = 1'b0, reset_n = 1'b0, send_start = 1'b0;
  logic                        isoc = 1'b0, coh = 1'b0, ppw = 1'b0, derr = 1'b0, chain = 1'b0;
  logic [3:0]                  seq = 4'h0, ch = 4'h0, cnt = 4'h0;
  logic [4:0]                  unit = 5'h00;
  logic [1:0]                  cset = 2'h0;
  logic [31:0]                 base = 32'h0000_0000, rev = 32'h0012_3400;
  logic [FIELD_BLOCK_BITS-1:0] blk = '0;
  logic                        busy, send_done, hv, p_isoc, p_coh, p_ppw, p_derr, p_chain, fv, b_hv, b_unsup, b_perr;
  logic [3:0]                  p_seq, p_ch, p_cnt, p_dwi;
  logic [4:0]                  p_unit;
  logic [7:0]                  p_sidx;
  logic [31:0]                 p_base, p_word, p_saddr;
  logic [63:0]                 h;
  logic [7:0]                  hdr_q[$], dat_q[$], sidx_q[$];
  logic [31:0]                 word_q[$], saddr_q[$];
  logic [3:0]                  dwi_q[$];
  int                          num_errors = 0, compares = 0, cycles = 0, hv_cnt = 0, b_hv_cnt = 0;
  int                          b_unsup_cnt = 0, b_perr_cnt = 0, h0, w0;

  fc_link_if link_a ();
  fc_link_if bad_link ();

  fc_request_generator fc_request_generator_inst (.clk(clk), .reset_n(reset_n), .link(link_a),
    .send_start(send_start), .isoc_mode(isoc), .coherent_mode(coh), .sequence_group_id(seq),
    .may_pass_posted_writes(ppw), .source_unit_number(unit), .channel_set_select(cset),
    .requested_channel_number(ch), .payload_error_bit(derr), .chain_bit(chain), .message_base_address(base),
    .payload_dwords_minus_one(cnt), .field_block(blk), .busy(busy), .send_done(send_done));
  fc_request_parser fc_request_parser_inst (.clk(clk), .reset_n(reset_n), .link(link_a),
    .reverse_sink_base_address(rev), .header_valid(hv), .isoc_mode(p_isoc), .coherent_mode(p_coh),
    .sequence_group_id(p_seq), .may_pass_posted_writes(p_ppw), .source_unit_number(p_unit),
    .requested_channel_number(p_ch), .payload_error_bit(p_derr), .chain_bit(p_chain), .message_base_address(p_base),
    .payload_dwords_minus_one(p_cnt), .field_valid(fv), .field_word(p_word), .dword_index(p_dwi),
    .first_stream_index(p_sidx), .first_stream_address(p_saddr), .unsupported(), .protocol_error());
  fc_request_parser fc_request_parser_inst_b (.clk(clk), .reset_n(reset_n), .link(bad_link),
    .reverse_sink_base_address(rev), .header_valid(b_hv), .isoc_mode(), .coherent_mode(), .sequence_group_id(),
    .may_pass_posted_writes(), .source_unit_number(), .requested_channel_number(), .payload_error_bit(),
    .chain_bit(), .message_base_address(), .payload_dwords_minus_one(), .field_valid(), .field_word(),
    .dword_index(), .first_stream_index(), .first_stream_address(), .unsupported(b_unsup), .protocol_error(b_perr));
  fc_link_chk fc_link_chk_inst (.clk(clk), .reset_n(reset_n), .lane_valid(link_a.lane_valid),
    .lane_ctl(link_a.lane_ctl), .lane_data(link_a.lane_data));

  // Clock and run limit
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      finish_test();
    end
  end

  // Record lane bytes and parser results where they have settled
  always @(negedge clk)
  begin
    if (link_a.lane_valid === 1'b1)
      if (link_a.lane_ctl) hdr_q.push_back(link_a.lane_data); else dat_q.push_back(link_a.lane_data);
    if (fv === 1'b1)
    begin
      word_q.push_back(p_word);
      dwi_q.push_back(p_dwi);
      sidx_q.push_back(p_sidx);
      saddr_q.push_back(p_saddr);
    end
    hv_cnt += int'(hv === 1'b1);
    b_hv_cnt += int'(b_hv === 1'b1);
    b_unsup_cnt += int'(b_unsup === 1'b1);
    b_perr_cnt += int'(b_perr === 1'b1);
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Raw per-stream fields with a pattern that differs per stream
  task automatic fill_blk(input int p);
    for (int k = 0; k < STREAMS_PER_MSG; k++)
      blk[2*k+:2] = 2'(k ^ (k >> 4) ^ p);
  endtask

  // Header expected on the lane for the current settings
  function automatic logic [63:0] exp_hdr();
    logic s2;
    s2 = (cset == CHANNEL_SET_TWO);
    return {base, 3'h0, 1'h1, 2'h0, cnt[3:2], cnt[1:0], 1'h0, derr, chain, s2 ? ch[2:0] : 3'h0,
            ppw, seq[1], s2 ? ch[3] : seq[0], unit, seq[3:2], 4'hb, isoc, coh};
  endfunction

  // Called at a falling edge; returns at the falling edge that shows done
  task automatic start_pkt;
    int n;
    n = 0;
    send_start = 1'b1;
    @(negedge clk);
    send_start = 1'b0;
    check_val(32'(busy), 32'h1, "busy after start");
    while (send_done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check_val(32'({send_done, busy}), 32'h2, "send done, busy low");
  endtask

  task automatic check_pkt;
    int nd;
    int k;
    nd = int'(cnt) + 1;
    h = exp_hdr();
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++)
      check_val(hdr_q[hdr_q.size()-8+i], h[8*i+:8], "header byte");
    for (int i = 0; i < 4 * nd; i++)
      check_val(dat_q[dat_q.size()-4*nd+i], blk[8*i+:8], "payload byte");
    for (int m = 0; m < nd; m++)
    begin
      k = word_q.size() - nd + m;
      check_val(word_q[k], blk[32*m+:32], "field word");
      check_val(dwi_q[k], 32'(m), "dword index");
      check_val(sidx_q[k], 32'(16 * m), "stream index");
      check_val(saddr_q[k], rev + 32'(16 * m), "stream address");
    end
    check_val({p_isoc, p_coh, p_ppw, p_derr, p_chain}, {isoc, coh, ppw, derr, chain}, "flags");
    check_val({p_seq[3:1], p_unit, p_cnt}, {seq[3:1], unit, cnt}, "header fields");
    check_val(p_base, base, "base address");
    check_val(p_ch, cset == CHANNEL_SET_TWO ? ch : {seq[0], 3'h0}, "channel");
  endtask

  task automatic raw_byte(input logic [7:0] b, input logic c);
    bad_link.lane_valid = 1'b1;
    bad_link.lane_ctl = c;
    bad_link.lane_data = b;
    @(negedge clk);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    bad_link.lane_valid = 1'b0;
    bad_link.lane_ctl = 1'b0;
    bad_link.lane_data = 8'h00;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    // Short messages over all command bit settings and channel sets 0 to 2
    for (int v = 0; v < 4; v++)
    begin
      {isoc, coh} = 2'(v);
      {derr, chain} = 2'(3 - v);
      ppw = ~coh;
      cset = v < 2 ? CHANNEL_SET_TWO : 2'(v - 2);
      ch = 4'(5 * v + 9);
      seq = 4'(v + 6);
      unit = 5'(7 * v + 3);
      cnt = 4'(v);
      base = 32'ha5c3_0f00 + 32'(v);
      fill_blk(v);
      start_pkt();
      check_pkt();
    end
    // Full-size message, the next one started on the done cycle
    h0 = hv_cnt;
    w0 = word_q.size();
    cnt = 4'hf;
    fill_blk(3);
    start_pkt();
    fill_blk(2);
    base = 32'h0000_ff00;
    cset = CHANNEL_SET_TWO;
    start_pkt();
    check_pkt();
    check_val(32'(hv_cnt - h0), 32'h2, "header count");
    check_val(32'(word_q.size() - w0), 32'h20, "field count");
    // Foreign formats on the second lane, then a good header
    cnt = 4'h0;
    for (int j = 0; j < 3; j++)
    begin
      h = exp_hdr() ^ (j == 0 ? 64'h4000_0000 : j == 1 ? 64'h1000_0000 : 64'h0);
      h0 = b_hv_cnt;
      w0 = b_unsup_cnt;
      for (int i = 0; i < 8; i++)
        raw_byte(h[8*i+:8], 1'b1);
      for (int i = 0; i < 4; i++)
        raw_byte(8'(37 * i + 1), 1'b0);
      bad_link.lane_valid = 1'b0;
      bad_link.lane_data = ~bad_link.lane_data;
      repeat (3) @(negedge clk);
      check_val(32'(b_unsup_cnt - w0), j < 2 ? 32'h1 : 32'h0, "unsupported");
      check_val(32'(b_hv_cnt - h0), j < 2 ? 32'h0 : 32'h1, "decoded");
    end
    // Header cut short by a payload byte gives one protocol error pulse
    raw_byte(h[7:0], 1'b1);
    raw_byte(8'h00, 1'b0);
    bad_link.lane_valid = 1'b0;
    repeat (2) @(negedge clk);
    check_val(32'({b_perr_cnt[1:0], b_unsup}), 32'h2, "cut header");
    finish_test();
  end
endmodule // stream_flow_control_packet_codec_tb
